// ---- rtl/umcs_pkg.sv ----
package umcs_pkg;

  // ****************************************************************
  // register map, word offsets on the plain register port
  // ****************************************************************
  localparam logic [3:0] UMCS_OFF_MODE     = 4'h0; // mode_definition_reg
  localparam logic [3:0] UMCS_OFF_FIFO     = 4'h1; // fifo_control_reg
  localparam logic [3:0] UMCS_OFF_RESUME   = 4'h2; // halt-release, read to resume
  localparam logic [3:0] UMCS_OFF_STATUS   = 4'h3; // engine state
  localparam logic [3:0] UMCS_OFF_IRQ_STAT = 4'h4; // sticky events, write one to clear
  localparam logic [3:0] UMCS_OFF_IRQ_MASK = 4'h5; // interrupt enables
  localparam logic [3:0] UMCS_OFF_TXDATA   = 4'h6; // transmit byte
  localparam logic [3:0] UMCS_OFF_RXDATA   = 4'h7; // last received byte

  // ****************************************************************
  // field positions and reset values
  // ****************************************************************
  localparam int         UMCS_FIFO_CLR_RX  = 1;
  localparam int         UMCS_FIFO_CLR_TX  = 2;
  localparam int         UMCS_EV_UNDERRUN  = 0;
  localparam int         UMCS_EV_CORRUPT   = 1;
  localparam int         UMCS_EV_RESUMED   = 2;
  localparam int         UMCS_EV_RXBYTE    = 3;
  localparam int         UMCS_EV_NUM       = 4;
  localparam logic [2:0] UMCS_MODE_RESET   = 3'h7; // disabled
  localparam logic [3:0] UMCS_MASK_RESET   = 4'h0;
  localparam logic [3:0] UMCS_FIFO_DEPTH   = 4'h8;

  // ****************************************************************
  // timing: one interconnect clock equals clk, functional clock is clk/div
  // ****************************************************************
  localparam logic [7:0] UMCS_BIT_DIV      = 8'h10; // interconnect clocks per functional tick, one functional tick per bit
  localparam logic [3:0] UMCS_SETTLE_CYC   = 4'h5;  // interconnect cycles after mode write
  localparam logic [3:0] UMCS_SETTLE_FCK   = 4'h5;  // functional ticks after mode write

  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [2:0]
  {
    UMCS_MODE_UART  = 3'b000,
    UMCS_MODE_IRDA  = 3'b001,
    UMCS_MODE_OFF   = 3'b111
  } umcs_mode_e;

  typedef enum logic [1:0]
  {
    UMCS_TX_IDLE    = 2'b00,
    UMCS_TX_SHIFT   = 2'b01,
    UMCS_TX_HALT    = 2'b10
  } umcs_tx_e;

  typedef struct packed
  {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } umcs_req_s;

endpackage

// ---- rtl/umcs_top.sv ----
`timescale 1ns/10ps
module umcs_top
  import umcs_pkg::*;
(
  // clock and reset
  input  wire logic             clk,
  input  wire logic             reset,
  // register port
  input  wire umcs_pkg::umcs_req_s req,
  output logic [7:0]            rdata,
  // serial line
  input  wire logic             rx_line,
  output logic                  tx_line,
  // interrupt
  output logic                  irq
);
  import umcs_pkg::*;

  // ****************************************************************
  // registers
  // ****************************************************************
  logic [2:0]           mode_q;
  logic [3:0]           mask_q, mask_d;
  logic [3:0]           stat_q, stat_d;
  logic [3:0]           tx_cnt_q, tx_cnt_d;  // fifo fill counters
  logic [3:0]           rx_cnt_q, rx_cnt_d;
  logic [7:0]           tx_buf_q;
  logic [7:0]           rx_buf_q;
  logic [3:0]           rx_bit_q;            // receive frame position, zero idle
  logic [7:0]           div_q;
  logic [3:0]           bit_q;
  logic [8:0]           sh_q;
  logic [7:0]           rdata_q;
  logic                 tx_q;
  logic [3:0]           settle_q;            // mode-change settle counter
  logic [3:0]           settle_f_q;
  umcs_tx_e             txs_q, txs_d;

  // ****************************************************************
  // decode
  // ****************************************************************
  wire logic            wr_mode   = req.wr && req.addr == UMCS_OFF_MODE;
  wire logic            rd_mode   = req.rd && req.addr == UMCS_OFF_MODE;
  wire logic            acc_mode  = wr_mode || rd_mode;
  wire logic            wr_fifo   = req.wr && req.addr == UMCS_OFF_FIFO;
  wire logic            rd_resume = req.rd && req.addr == UMCS_OFF_RESUME;
  wire logic            wr_istat  = req.wr && req.addr == UMCS_OFF_IRQ_STAT;
  wire logic            wr_imask  = req.wr && req.addr == UMCS_OFF_IRQ_MASK;
  wire logic            wr_tx     = req.wr && req.addr == UMCS_OFF_TXDATA;
  wire logic            fck       = div_q == 8'h00;          // functional clock tick
  wire logic            bit_tick  = fck;
  wire logic            is_irda   = mode_q == UMCS_MODE_IRDA;
  wire logic            is_uart   = mode_q == UMCS_MODE_UART;
  wire logic            busy      = txs_q == UMCS_TX_SHIFT;
  wire logic            settling  = settle_q != 4'h0 || settle_f_q != 4'h0;
  // glitch: a mode access while shifting in IrDA mode fakes an underrun
  wire logic            fake_urun = acc_mode && busy && is_irda;
  wire logic            corrupt   = acc_mode && busy && is_uart;
  wire logic            clr_tx    = wr_fifo && req.wdata[UMCS_FIFO_CLR_TX];
  wire logic            clr_rx    = wr_fifo && req.wdata[UMCS_FIFO_CLR_RX];
  wire logic            start_tx  = txs_q == UMCS_TX_IDLE && tx_cnt_q != 4'h0
                                    && !settling && mode_q != UMCS_MODE_OFF;
  wire logic            tx_done   = busy && bit_tick && bit_q == 4'h9;
  wire logic            resumed   = rd_resume && txs_q == UMCS_TX_HALT;
  wire logic            rx_in     = rx_line;
  // receive framing: in UART mode a low line at an idle tick opens a frame, tick nine is the stop bit
  wire logic            rx_start  = bit_tick && is_uart && rx_bit_q == 4'h0 && !rx_in;
  wire logic            rx_done   = bit_tick && rx_bit_q == 4'h9;
  wire logic            rx_ready  = rx_cnt_q != 4'h0;
  wire logic [UMCS_EV_NUM-1:0] ev = {rx_done, resumed, corrupt, fake_urun};

  // ****************************************************************
  // transmit state machine
  // ****************************************************************
  always_comb
  begin
    txs_d = txs_q;
    unique case (txs_q)
      UMCS_TX_IDLE:
        if (start_tx)
          txs_d = UMCS_TX_SHIFT;
      UMCS_TX_SHIFT:
        if (fake_urun)
          txs_d = UMCS_TX_HALT;
        else if (tx_done || clr_tx)
          txs_d = UMCS_TX_IDLE;
      UMCS_TX_HALT:
        if (rd_resume)
          txs_d = UMCS_TX_IDLE;
        else
          txs_d = UMCS_TX_HALT;
      default:
        txs_d = UMCS_TX_IDLE;
    endcase
  end

  // ****************************************************************
  // fifo counters, interrupt status and mask
  // ****************************************************************
  always_comb
  begin
    tx_cnt_d = tx_cnt_q;
    if (clr_tx)
      tx_cnt_d = 4'h0;
    else if (wr_tx && tx_cnt_q != UMCS_FIFO_DEPTH)
      tx_cnt_d = tx_cnt_q + 4'h1;
    else if (tx_done && tx_cnt_q != 4'h0)
      tx_cnt_d = tx_cnt_q - 4'h1;
    rx_cnt_d = rx_cnt_q;
    if (clr_rx)
      rx_cnt_d = 4'h0;
    else if (rx_done && rx_cnt_q != UMCS_FIFO_DEPTH)
      rx_cnt_d = rx_cnt_q + 4'h1;
    mask_d   = wr_imask ? req.wdata[3:0] : mask_q;
    // set wins over a write-one clear
    stat_d   = (stat_q & ~(wr_istat ? req.wdata[3:0] : 4'h0)) | ev;
  end

  // ****************************************************************
  // clocked state
  // ****************************************************************
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      mode_q     <= UMCS_MODE_RESET;
      mask_q     <= UMCS_MASK_RESET;
      stat_q     <= 4'h0;
      tx_cnt_q   <= 4'h0;
      rx_cnt_q   <= 4'h0;
      txs_q      <= UMCS_TX_IDLE;
      settle_q   <= 4'h0;
      settle_f_q <= 4'h0;
      div_q      <= 8'h00;
    end
    else
    begin
      if (wr_mode)
        mode_q <= req.wdata[2:0];
      mask_q   <= mask_d;
      stat_q   <= stat_d;
      tx_cnt_q <= tx_cnt_d;
      rx_cnt_q <= rx_cnt_d;
      txs_q    <= txs_d;
      div_q    <= fck ? UMCS_BIT_DIV - 8'h01 : div_q - 8'h01;
      // engine kept from starting a frame while the new mode settles
      if (wr_mode)
        settle_q <= UMCS_SETTLE_CYC;
      else if (settle_q != 4'h0)
        settle_q <= settle_q - 4'h1;
      if (wr_mode)
        settle_f_q <= UMCS_SETTLE_FCK;
      else if (fck && settle_f_q != 4'h0)
        settle_f_q <= settle_f_q - 4'h1;
    end
  end

  // ****************************************************************
  // datapath: shifter, buffers, read data
  // ****************************************************************
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      tx_q    <= 1'b1;
      sh_q    <= 9'h1ff;
      bit_q   <= 4'h0;
      tx_buf_q <= 8'h00;
      rx_buf_q <= 8'h00;
      rx_bit_q <= 4'h0;
      rdata_q <= 8'h00;
    end
    else
    begin
      if (wr_tx)
        tx_buf_q <= req.wdata;
      if (start_tx)
      begin
        sh_q  <= {tx_buf_q, 1'b0};
        bit_q <= 4'h0;
      end
      else if (busy && bit_tick)
      begin
        tx_q  <= sh_q[0];
        sh_q  <= {1'b1, sh_q[8:1]};
        bit_q <= bit_q + 4'h1;
      end
      else if (!busy)
        tx_q <= 1'b1;                                       // halted line idles high
      // receive frame: start, eight data bits lsb first, stop
      if (rx_start)
        rx_bit_q <= 4'h1;
      else if (rx_done)
        rx_bit_q <= 4'h0;
      else if (bit_tick && rx_bit_q != 4'h0)
      begin
        rx_buf_q <= {rx_in, rx_buf_q[7:1]};
        rx_bit_q <= rx_bit_q + 4'h1;
      end
      unique case (req.addr)
        UMCS_OFF_MODE:     rdata_q <= req.rd ? {5'h00, mode_q} : 8'h00;
        UMCS_OFF_STATUS:   rdata_q <= req.rd ? {settling, txs_q, rx_ready, tx_cnt_q} : 8'h00;
        UMCS_OFF_IRQ_STAT: rdata_q <= req.rd ? {4'h0, stat_q} : 8'h00;
        UMCS_OFF_IRQ_MASK: rdata_q <= req.rd ? {4'h0, mask_q} : 8'h00;
        UMCS_OFF_RXDATA:   rdata_q <= req.rd ? rx_buf_q : 8'h00;
        default:           rdata_q <= 8'h00;
      endcase
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign rdata   = rdata_q;
  assign tx_line = tx_q;
  assign irq     = |(stat_q & mask_q);

endmodule

// ---- test/umcs_properties.sv ----
`timescale 1ns/10ps
module umcs_checker
  import umcs_pkg::*;
(
  // clock, reset and pins
  input wire logic                clk,
  input wire logic                reset,
  input wire umcs_pkg::umcs_req_s req,
  input wire logic [7:0]          rdata,
  input wire logic                rx_line,
  input wire logic                tx_line,
  input wire logic                irq
);
  logic       stat_rd_q;
  logic       halt_seen_q;
  logic [3:0] mask_q;
  wire        irq_wr = req.wr && (req.addr == UMCS_OFF_IRQ_STAT || req.addr == UMCS_OFF_IRQ_MASK);
  wire        release_hit = (req.rd && req.addr == UMCS_OFF_RESUME) ||
                            (req.wr && req.addr == UMCS_OFF_FIFO && req.wdata[UMCS_FIFO_CLR_TX]);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // track status reads, a seen halt and the mask
  always_ff @(posedge clk)
  begin
    stat_rd_q   <= req.rd && req.addr == UMCS_OFF_STATUS;
    halt_seen_q <= reset || release_hit ? 1'b0 :
                   (stat_rd_q && rdata[6:5] == UMCS_TX_HALT) ? 1'b1 : halt_seen_q;
    mask_q      <= reset ? UMCS_MASK_RESET :
                   (req.wr && req.addr == UMCS_OFF_IRQ_MASK) ? req.wdata[3:0] : mask_q;
  end
  // ****************************************************************
  // properties
  // ****************************************************************
  sequence s_unmapped_rd;
    req.rd && req.addr > UMCS_OFF_RXDATA;
  endsequence
  sequence s_quiet_halt;
    halt_seen_q && !req.rd && !req.wr;
  endsequence
  AST_RD_ZERO: assert property (!$past(req.rd) |-> rdata == 8'h00)
    else $error("read data not zero outside read answer");
  AST_UNMAPPED: assert property (s_unmapped_rd |=> rdata == 8'h00)
    else $error("unmapped read not zero");
  AST_RST_TX: assert property ($past(reset) |-> tx_line)
    else $error("serial out not idle after reset");
  AST_RST_IRQ: assert property ($past(reset) |-> !irq)
    else $error("interrupt high after reset");
  AST_IRQ_FALL: assert property ($fell(irq) |-> $past(irq_wr) || $past(reset))
    else $error("interrupt dropped without clear or mask");
  AST_IRQ_MASKED: assert property (mask_q == 4'h0 |-> !irq)
    else $error("interrupt high while fully masked");
  AST_HALT_STICKY: assert property (stat_rd_q && halt_seen_q |-> rdata[6:5] == UMCS_TX_HALT)
    else $error("halt ended without release read");
  AST_HALT_FROZEN: assert property (s_quiet_halt |=> $stable(tx_line))
    else $error("serial out moved while halted");
endmodule
bind umcs_top umcs_checker u_chk (.clk(clk), .reset(reset), .req(req), .rdata(rdata),
                                  .rx_line(rx_line), .tx_line(tx_line), .irq(irq));

// ---- test/umcs_peer.sv ----
`timescale 1ns/10ps
module umcs_peer #(parameter int BIT_CLKS = 16)
(
  // clock and line toward the block
  input wire logic clk,
  input wire logic tx_line,
  output logic     rx_line
);
  // line idles high between frames
  initial rx_line = 1'b1;
  // start bit, eight bits lsb first, stop bit
  task automatic send_byte(logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      @(posedge clk);
      rx_line <= f[i];
      repeat (BIT_CLKS - 1) @(posedge clk);
    end
  endtask
  // wait for a start bit, then sample each data bit in its middle
  task automatic recv_byte(output logic [7:0] b);
    @(negedge tx_line);
    repeat (BIT_CLKS / 2) @(posedge clk);
    for (int i = 0; i < 8; i++)
    begin
      repeat (BIT_CLKS) @(posedge clk);
      b[i] = tx_line;
    end
  endtask
endmodule

// ---- test/tb_umcs_top.sv ----
`timescale 1ns/10ps
module tb_umcs_top;
  import umcs_pkg::*;
  logic       clk, reset, rx_line, tx_line, irq;
  logic [7:0] rdata, got;
  umcs_req_s  req;
  int         miscompares, check_count;
  umcs_top u_dut (.clk(clk), .reset(reset), .req(req), .rdata(rdata),
                  .rx_line(rx_line), .tx_line(tx_line), .irq(irq));
  umcs_peer u_peer (.clk(clk), .tx_line(tx_line), .rx_line(rx_line));
  // ****************************************************************
  // clock, bus tasks and checks
  // ****************************************************************
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(string what, logic [7:0] exp, logic [7:0] seen);
    check_count++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(logic [3:0] a, logic [7:0] d);
    @(posedge clk);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    req.wr <= 1'b0;
    #1;
  endtask
  task automatic rd(logic [3:0] a);
    @(posedge clk);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    req.rd <= 1'b0;
    #1 got = rdata;
  endtask
  // poll the engine state with a bounded count
  task automatic wait_tx(logic [1:0] st);
    int n = 0;
    do
    begin
      rd(UMCS_OFF_STATUS);
      n++;
    end while (got[6:5] !== st && n < 3000);
    chk("tx state", {6'h00, st}, {6'h00, got[6:5]});
  endtask
  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_defaults();
    rd(UMCS_OFF_MODE);
    chk("mode reset", {5'h00, UMCS_MODE_RESET}, got);
    rd(UMCS_OFF_IRQ_MASK);
    chk("mask reset", {4'h0, UMCS_MASK_RESET}, got);
    rd(4'hc);
    chk("unmapped", 8'h00, got);
    $display("defaults done");
  endtask
  task automatic t_irda_freeze();
    wr(UMCS_OFF_IRQ_MASK, 8'h0f);
    wr(UMCS_OFF_TXDATA, 8'ha5);
    wr(UMCS_OFF_MODE, {5'h00, UMCS_MODE_IRDA});
    wait_tx(UMCS_TX_SHIFT);
    wr(UMCS_OFF_MODE, {5'h00, UMCS_MODE_IRDA});
    repeat (100) @(posedge clk);
    wait_tx(UMCS_TX_HALT);
    rd(UMCS_OFF_IRQ_STAT);
    chk("underrun", 8'h01, got & 8'h03);
    chk("irq", 8'h01, {7'h00, irq});
    wr(UMCS_OFF_FIFO, 8'h06);
    rd(UMCS_OFF_STATUS);
    chk("tx count", 8'h00, got & 8'h0f);
    rd(UMCS_OFF_RESUME);
    rd(UMCS_OFF_STATUS);
    chk("released", {6'h00, UMCS_TX_IDLE}, {6'h00, got[6:5]});
    rd(UMCS_OFF_IRQ_STAT);
    chk("resumed", 8'h04, got & 8'h04);
    wr(UMCS_OFF_IRQ_STAT, 8'h0f);
    chk("irq cleared", 8'h00, {7'h00, irq});
    $display("irda freeze done");
  endtask
  task automatic t_uart();
    wr(UMCS_OFF_MODE, {5'h00, UMCS_MODE_UART});
    repeat (100) @(posedge clk);
    wr(UMCS_OFF_FIFO, 8'h06);
    wr(UMCS_OFF_TXDATA, 8'h5a);
    wait_tx(UMCS_TX_SHIFT);
    rd(UMCS_OFF_MODE);
    rd(UMCS_OFF_IRQ_STAT);
    chk("corrupt", 8'h02, got & 8'h03);
    wr(UMCS_OFF_IRQ_MASK, 8'h00);
    chk("irq masked", 8'h00, {7'h00, irq});
    wr(UMCS_OFF_IRQ_MASK, 8'h0f);
    chk("irq unmasked", 8'h01, {7'h00, irq});
    wait_tx(UMCS_TX_IDLE);
    wr(UMCS_OFF_IRQ_STAT, 8'h0f);
    wr(UMCS_OFF_TXDATA, 8'hc3);
    u_peer.recv_byte(got);
    chk("tx byte", 8'hc3, got);
    u_peer.send_byte(8'h3c);
    repeat (20) @(posedge clk);
    rd(UMCS_OFF_STATUS);
    chk("rx waiting", 8'h10, got & 8'h10);
    wr(UMCS_OFF_FIFO, 8'h06);
    rd(UMCS_OFF_STATUS);
    chk("rx count cleared", 8'h00, got & 8'h10);
    rd(UMCS_OFF_RXDATA);
    chk("rx byte", 8'h3c, got);
    rd(UMCS_OFF_IRQ_STAT);
    chk("rx event", 8'h08, got & 8'h08);
    $display("uart done");
  endtask
  task automatic t_reset();
    @(posedge clk);
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    rd(UMCS_OFF_MODE);
    chk("mode after reset", {5'h00, UMCS_MODE_RESET}, got);
    rd(UMCS_OFF_IRQ_STAT);
    chk("status after reset", 8'h00, got);
    chk("irq after reset", 8'h00, {7'h00, irq});
    $display("reset done");
  endtask
  // watchdog against a hang
  initial
  begin
    #800_000;
    miscompares++;
    report_and_stop();
  end
  // reset then scenarios
  initial
  begin
    req = '0;
    reset = 1'b1;
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    t_defaults();
    t_irda_freeze();
    t_uart();
    t_reset();
    report_and_stop();
  end
endmodule
